// [gac_host_model.sv]
/* Far side of gac_top: gate source, live sample counter and a sink
 * that drains every stored sample. Assumes go pulses for one clock. */
`timescale 1ns/1ps
module gac_host_model
(
    input wire logic clk, // sample clock
    input wire logic rst_n, // async reset, low
    input wire logic go, // start one gate
    input wire logic [15:0] glen, // gate length in clocks
    input wire logic clr, // clear sink counters
    input wire logic store_valid, // stored sample strobe
    input wire logic [15:0] store_data, // stored sample
    output logic gate_in, // gate condition
    output logic [15:0] sample_data, // live sample
    output logic [31:0] n_stored, // samples drained
    output logic [15:0] first_data, // first sample drained
    output logic [15:0] gate_sample // live sample at gate start
);
    logic [15:0] left;
    assign gate_in = left != 16'h0000;

    // counting samples make each stored value name its own clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample_data <= 16'h0000;
            left <= 16'h0000;
            gate_sample <= 16'h0000;
        end
        else
        begin
            sample_data <= sample_data + 16'h0001;
            if (go)
            begin
                left <= glen;
                gate_sample <= sample_data + 16'h0001;
            end
            else if (left != 16'h0000)
                left <= left - 16'h0001;
        end
    end

    // sink never stalls, as a streaming host must
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            n_stored <= 32'h00000000;
            first_data <= 16'h0000;
        end
        else if (clr)
            n_stored <= 32'h00000000;
        else if (store_valid)
        begin
            n_stored <= n_stored + 32'h00000001;
            if (n_stored == 32'h00000000)
                first_data <= store_data;
        end
    end
endmodule

// [gac_pkg.sv]
/*
 * Shared constants for the gated acquisition control block: register
 * indices, field positions, mode codes, reset values and sizes.
 * Assumes a 16-bit AXI4-Lite byte address where byte address = index * 4.
 */
package gac_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is index * 4)
    // ------------------------------------------------------------------
    localparam logic [13:0] GAC_IDX_MODE = 14'h251C;
    localparam logic [13:0] GAC_IDX_MEMSIZE_LO = 14'h2710;
    localparam logic [13:0] GAC_IDX_MEMSIZE_HI = 14'h2711;
    localparam logic [13:0] GAC_IDX_GATE_LIMIT = 14'h2724;
    localparam logic [13:0] GAC_IDX_PRE = 14'h272E;
    localparam logic [13:0] GAC_IDX_POST_LO = 14'h2774;
    localparam logic [13:0] GAC_IDX_POST_HI = 14'h2775;
    localparam logic [13:0] GAC_IDX_CTRL = 14'h27D8;
    localparam logic [13:0] GAC_IDX_STATUS = 14'h27D9;
    localparam logic [13:0] GAC_IDX_GATES = 14'h27DA;
    localparam logic [13:0] GAC_IDX_STORED = 14'h27DB;
    localparam logic [13:0] GAC_IDX_CHANS = 14'h27DC;

    // ------------------------------------------------------------------
    // field positions and codes
    // ------------------------------------------------------------------
    localparam int GAC_CTRL_START = 0;
    localparam int GAC_CTRL_STOP = 1;
    localparam int GAC_STAT_RUN = 0;
    localparam int GAC_STAT_DONE = 1;
    localparam int GAC_STAT_FIFO = 2;
    localparam logic [31:0] GAC_MODE_STD_GATE = 32'h00000004;
    localparam logic [31:0] GAC_MODE_FIFO_GATE = 32'h00000040;
    localparam logic [1:0] GAC_CHANS_ONE = 2'h0;

    // ------------------------------------------------------------------
    // reset values and sizes
    // ------------------------------------------------------------------
    localparam logic [31:0] GAC_MODE_RST = 32'h00000000;
    localparam logic [63:0] GAC_MEMSIZE_RST = 64'h0000000000000008;
    localparam logic [31:0] GAC_PRE_RST = 32'h00000004;
    localparam logic [63:0] GAC_POST_RST = 64'h0000000000000004;
    localparam int GAC_BYTES_PER_SAMPLE = 2;
    localparam int GAC_HIST_AW = 13;
    localparam int GAC_HIST_DEPTH = 1 << GAC_HIST_AW;
    localparam logic [1:0] GAC_RESP_OKAY = 2'h0;
    localparam logic [1:0] GAC_RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        GAC_IDLE = 2'b00,
        GAC_RUN = 2'b01,
        GAC_DONE = 2'b10
    } gac_state_e;

endpackage

// [gac_top.sv]
/*
 * Gated acquisition control: decides, sample by sample, which samples of
 * the incoming stream are stored, with pre-gate history, gate-end
 * alignment and post-gate extension, for standard and streaming modes.
 * Assumes one sample per clock on sample_data, a gate condition already
 * evaluated upstream on gate_in, and a memory or streaming sink that
 * accepts every stored sample at once.
 */
`timescale 1ns/1ps

// Function
// - store only gate segments, with their pre and post samples
// - pause at gate end, resume next gate
// - standard mode stops at programmed sample count
// - memory size register read and write
// - mode value 4 selects standard gating
// - mode value 64 selects streaming gating
// - streaming ends on stop or gate count
// - gate count zero means run unlimited
// - nonzero gate count stops streaming after that many
// - two bytes per stored sample
// - streaming data continuously offered and drained
// - pretrigger samples stored before each gate
// - posttrigger samples stored after each gate
// - gate length rounded up to even with one channel
module gac_top
    import gac_pkg::*;
(
    input wire logic clk, // 250 MHz sample clock
    input wire logic rst_n, // async reset, active low
    input wire logic [15:0] awaddr, // axi write address
    input wire logic awvalid, // axi write address valid
    output logic awready, // axi write address ready
    input wire logic [31:0] wdata, // axi write data
    input wire logic [3:0] wstrb, // axi write byte strobes
    input wire logic wvalid, // axi write data valid
    output logic wready, // axi write data ready
    output logic [1:0] bresp, // axi write response
    output logic bvalid, // axi write response valid
    input wire logic bready, // axi write response ready
    input wire logic [15:0] araddr, // axi read address
    input wire logic arvalid, // axi read address valid
    output logic arready, // axi read address ready
    output logic [31:0] rdata, // axi read data
    output logic [1:0] rresp, // axi read response
    output logic rvalid, // axi read valid
    input wire logic rready, // axi read ready
    input wire logic [15:0] sample_data, // live sample, one per clock
    input wire logic gate_in, // gate condition, high when true
    output logic store_valid, // stored sample strobe
    output logic [15:0] store_data, // stored sample value
    output logic [63:0] store_addr, // byte offset of stored sample
    output logic acq_running // acquisition in progress
);

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [31:0] mode_sel;
    logic [63:0] total_samples;
    logic [31:0] gate_limit;
    logic [31:0] pre_samples;
    logic [63:0] post_samples;
    logic [1:0] chans;
    logic aw_held;
    logic w_held;
    logic [13:0] aw_idx;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    gac_state_e state;
    logic fifo_mode;
    logic [63:0] stored;
    logic [31:0] gates;
    logic gate_q;
    logic seg;
    logic par;
    logic [63:0] tail;
    logic [GAC_HIST_AW-1:0] wp;
    logic [15:0] hist [0:GAC_HIST_DEPTH-1];
    logic wr_fire;
    logic start_cmd;
    logic stop_cmd;
    logic running;
    logic allow_new;
    logic rise;
    logic gate_on;
    logic fall_acc;
    logic store;
    logic [63:0] seg_tail;
    logic [GAC_HIST_AW-1:0] rp;
    logic limit_met;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic wr_hit;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign wr_fire = aw_held && w_held && !bvalid;

    always_comb
    begin
        case (aw_idx)
            GAC_IDX_MODE, GAC_IDX_MEMSIZE_LO, GAC_IDX_MEMSIZE_HI, GAC_IDX_GATE_LIMIT, GAC_IDX_PRE,
            GAC_IDX_POST_LO, GAC_IDX_POST_HI, GAC_IDX_CTRL, GAC_IDX_CHANS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 14'h0000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= GAC_RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_idx <= awaddr[15:2];
            end
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? GAC_RESP_OKAY : GAC_RESP_DECERR;
            end
            else if (bvalid && bready)
            begin
                bvalid <= 1'b0;
            end
        end
    end

    // configuration registers, byte lanes honoured
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_sel <= GAC_MODE_RST;
            total_samples <= GAC_MEMSIZE_RST;
            gate_limit <= 32'h00000000;
            pre_samples <= GAC_PRE_RST;
            post_samples <= GAC_POST_RST;
            chans <= GAC_CHANS_ONE;
        end
        else if (wr_fire)
        begin
            case (aw_idx)
                GAC_IDX_MODE: mode_sel <= merge(mode_sel, w_data, w_strb);
                GAC_IDX_MEMSIZE_LO: total_samples[31:0] <= merge(total_samples[31:0], w_data, w_strb);
                GAC_IDX_MEMSIZE_HI: total_samples[63:32] <= merge(total_samples[63:32], w_data, w_strb);
                GAC_IDX_GATE_LIMIT: gate_limit <= merge(gate_limit, w_data, w_strb);
                GAC_IDX_PRE: pre_samples <= merge(pre_samples, w_data, w_strb);
                GAC_IDX_POST_LO: post_samples[31:0] <= merge(post_samples[31:0], w_data, w_strb);
                GAC_IDX_POST_HI: post_samples[63:32] <= merge(post_samples[63:32], w_data, w_strb);
                GAC_IDX_CHANS: chans <= w_strb[0] ? w_data[1:0] : chans;
                default: ;
            endcase
        end
    end

    assign start_cmd = wr_fire && aw_idx == GAC_IDX_CTRL && w_strb[0] && w_data[GAC_CTRL_START];
    assign stop_cmd = wr_fire && aw_idx == GAC_IDX_CTRL && w_strb[0] && w_data[GAC_CTRL_STOP];

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    assign arready = !rvalid;

    always_comb
    begin
        rd_hit = 1'b1;
        case (araddr[15:2])
            GAC_IDX_MODE: rd_mux = mode_sel;
            GAC_IDX_MEMSIZE_LO: rd_mux = total_samples[31:0];
            GAC_IDX_MEMSIZE_HI: rd_mux = total_samples[63:32];
            GAC_IDX_GATE_LIMIT: rd_mux = gate_limit;
            GAC_IDX_PRE: rd_mux = pre_samples;
            GAC_IDX_POST_LO: rd_mux = post_samples[31:0];
            GAC_IDX_POST_HI: rd_mux = post_samples[63:32];
            GAC_IDX_CTRL: rd_mux = 32'h00000000;
            GAC_IDX_STATUS: rd_mux = {29'h00000000, fifo_mode, state == GAC_DONE, running};
            GAC_IDX_GATES: rd_mux = gates;
            GAC_IDX_STORED: rd_mux = stored[31:0];
            GAC_IDX_CHANS: rd_mux = {30'h00000000, chans};
            default:
            begin
                rd_mux = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= GAC_RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_hit ? GAC_RESP_OKAY : GAC_RESP_DECERR;
        end
        else if (rvalid && rready)
        begin
            rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // gate qualification and segment timing
    // ------------------------------------------------------------------
    assign running = state == GAC_RUN;
    assign acq_running = running;
    // zero limit never blocks a gate, so streaming runs until stopped
    assign limit_met = fifo_mode && gate_limit != 32'h00000000 && gates >= gate_limit;
    assign allow_new = running && !limit_met;
    assign rise = gate_in && !gate_q;
    // a gate still high from an accepted start keeps going
    assign gate_on = gate_in && (gate_q ? seg : allow_new);
    assign fall_acc = running && seg && gate_q && !gate_in;
    // extension after gate end: alignment pad, post, and the pre delay
    assign seg_tail = post_samples + {32'h00000000, pre_samples}
        + {63'h0, chans == GAC_CHANS_ONE && par};
    assign store = running && (gate_on || fall_acc || tail != 64'h0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_q <= 1'b0;
            seg <= 1'b0;
            par <= 1'b0;
            tail <= 64'h0;
        end
        else
        begin
            gate_q <= gate_in;
            if (!running)
            begin
                seg <= 1'b0;
                tail <= 64'h0;
                par <= 1'b0;
            end
            else
            begin
                seg <= gate_on || fall_acc || tail > 64'h1;
                if (gate_on)
                begin
                    tail <= 64'h0;
                    par <= rise ? 1'b1 : !par;
                end
                else if (fall_acc)
                begin
                    tail <= seg_tail - 64'h1;
                end
                else if (tail != 64'h0)
                begin
                    tail <= tail - 64'h1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= GAC_IDLE;
            fifo_mode <= 1'b0;
            stored <= 64'h0;
            gates <= 32'h00000000;
        end
        else
        begin
            case (state)
                GAC_IDLE, GAC_DONE:
                begin
                    // other mode codes are not gated modes; start is ignored
                    if (start_cmd && (mode_sel == GAC_MODE_STD_GATE || mode_sel == GAC_MODE_FIFO_GATE))
                    begin
                        state <= GAC_RUN;
                        fifo_mode <= mode_sel == GAC_MODE_FIFO_GATE;
                        stored <= 64'h0;
                        gates <= 32'h00000000;
                    end
                end
                GAC_RUN:
                begin
                    if (store)
                    begin
                        stored <= stored + 64'h1;
                    end
                    if (rise && allow_new)
                    begin
                        gates <= gates + 32'h00000001;
                    end
                    if (stop_cmd)
                    begin
                        state <= GAC_DONE;
                    end
                    else if (!fifo_mode && store && stored + 64'h1 >= total_samples)
                    begin
                        state <= GAC_DONE;
                    end
                    else if (limit_met && !store)
                    begin
                        state <= GAC_DONE;
                    end
                end
                default: state <= GAC_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pre-gate history and stored sample output
    // ------------------------------------------------------------------
    // every sample enters the ring, paused or not, so history is ready
    always_ff @(posedge clk)
    begin
        hist[wp] <= sample_data;
    end

    // output runs pre_samples behind live time; gate start opens the window
    assign rp = wp - pre_samples[GAC_HIST_AW-1:0];

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp <= '0;
            store_valid <= 1'b0;
            store_data <= 16'h0000;
            store_addr <= 64'h0;
        end
        else
        begin
            wp <= wp + 1'b1;
            store_valid <= store;
            store_data <= hist[rp];
            store_addr <= stored * GAC_BYTES_PER_SAMPLE;
        end
    end

endmodule

// [gac_top_monitor.sv]
/* Checker for gac_top: axi4-lite handshakes and the stored sample stream.
 * Assumes it is bound to gac_top and sees only that module's ports. */
`timescale 1ns/1ps
module gac_top_monitor
    import gac_pkg::*;
(
    input wire logic clk, // sample clock
    input wire logic rst_n, // async reset, low
    input wire logic awvalid, // aw valid
    input wire logic awready, // aw ready
    input wire logic wvalid, // w valid
    input wire logic wready, // w ready
    input wire logic [1:0] bresp, // b response
    input wire logic bvalid, // b valid
    input wire logic bready, // b ready
    input wire logic arvalid, // ar valid
    input wire logic arready, // ar ready
    input wire logic [31:0] rdata, // read data
    input wire logic rvalid, // r valid
    input wire logic rready, // r ready
    input wire logic gate_in, // gate condition
    input wire logic store_valid, // store strobe
    input wire logic [63:0] store_addr, // store byte offset
    input wire logic acq_running // run level
);
    // ------
    // stores since run start
    // ------
    logic run_q;
    logic [63:0] n_st;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q <= 1'b0;
            n_st <= 64'h0;
        end
        else
        begin
            run_q <= acq_running;
            // a new run restarts the byte offsets at zero
            if (acq_running && !run_q)
                n_st <= 64'h0;
            else if (store_valid)
                n_st <= n_st + 64'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_gate_start; $rose(store_valid) |-> $past(gate_in); endproperty
    a_gate_start: assert property (p_gate_start) else $error("segment began without gate");
    property p_halt; !store_valid && !gate_in |=> !store_valid; endproperty
    a_halt: assert property (p_halt) else $error("store while paused");
    property p_run_only; store_valid |-> $past(acq_running); endproperty
    a_run_only: assert property (p_run_only) else $error("store after run ended");
    property p_addr; store_valid |-> store_addr == {n_st[62:0], 1'b0}; endproperty
    a_addr: assert property (p_addr) else $error("store offset not two bytes per sample");
    property p_wr_ans; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write response late");
    property p_b_hold; bvalid && !bready |=> bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_busy; bvalid |-> !awready && !wready; endproperty
    a_busy: assert property (p_busy) else $error("write taken while answering");
    property p_rd_ans; arvalid && arready |=> rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer not held");

    c_seg: cover property ($fell(store_valid));
    c_done: cover property ($fell(acq_running));
    c_decerr: cover property (bvalid && bresp == GAC_RESP_DECERR);
endmodule

bind gac_top gac_top_monitor u_mon (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .gate_in(gate_in), .store_valid(store_valid), .store_addr(store_addr), .acq_running(acq_running));

// [tb.sv]
/* Self-checking bench for gac_top: registers over axi4-lite, standard
 * and streaming gated runs. Assumes gac_host_model drives the far side. */
`timescale 1ns/1ps
module tb
    import gac_pkg::*;
;
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, go, clr;
    logic arvalid, arready, rvalid, rready, gate_in, store_valid, acq_running;
    logic [15:0] awaddr, araddr, sample_data, store_data, glen, first_data, gate_sample;
    logic [31:0] wdata, rdata, n_stored, rd_v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [63:0] store_addr;
    int miscompares = 0;
    int compares = 0;

    gac_top dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .sample_data, .gate_in, .store_valid, .store_data, .store_addr, .acq_running);
    gac_host_model host (.clk, .rst_n, .go, .glen, .clr, .store_valid, .store_data, .gate_in,
        .sample_data, .n_stored, .first_data, .gate_sample);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic hang(input string nm);
        miscompares++;
        $display("ERROR %s expected answer seen timeout", nm);
        give_verdict();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ------
    // axi4-lite master: handshakes judged at the falling edge
    // ------
    task automatic wr(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er = GAC_RESP_OKAY);
        logic ah, wh, bh;
        logic [1:0] rsp;
        bh = 1'b0;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !bh; n++)
        begin
            @(negedge clk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid && bready;
            rsp = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
        end
        if (!bh) hang("bvalid");
        chk("bresp", rsp, er);
    endtask

    task automatic rd(input logic [13:0] idx, input logic [1:0] er = GAC_RESP_OKAY);
        logic ah, rh;
        logic [1:0] rsp;
        rh = 1'b0;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !rh; n++)
        begin
            @(negedge clk);
            ah = arvalid && arready;
            rh = rvalid && rready;
            rsp = rresp;
            rd_v = rdata;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
        if (!rh) hang("rvalid");
        chk("rresp", rsp, er);
    endtask

    task automatic gate(input logic [15:0] n);
        @(posedge clk);
        glen <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        cyc(n + 24);
    endtask

    task automatic wait_idle();
        for (int n = 0; n < 500; n++)
        begin
            @(negedge clk);
            if (acq_running === 1'b0)
                return;
        end
        hang("acq_running");
    endtask

    task automatic run(input logic [31:0] mode, input logic [31:0] limit);
        wr(GAC_IDX_MODE, mode);
        wr(GAC_IDX_GATE_LIMIT, limit);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr(GAC_IDX_CTRL, 32'h00000001);
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_regs();
        rd(GAC_IDX_MODE);
        chk("mode reset", rd_v, GAC_MODE_RST);
        rd(GAC_IDX_MEMSIZE_LO);
        chk("memsize reset", rd_v, GAC_MEMSIZE_RST[31:0]);
        wr(GAC_IDX_MEMSIZE_LO, 32'h00000020);
        rd(GAC_IDX_MEMSIZE_LO);
        chk("memsize rw", rd_v, 32'h00000020);
        wr(GAC_IDX_PRE, 32'h00000004);
        wr(GAC_IDX_POST_LO, 32'h00000004);
        rd(GAC_IDX_PRE);
        chk("pre rw", rd_v, 32'h00000004);
        rd(14'h0000, GAC_RESP_DECERR);
        wr(14'h0000, 32'h0000FFFF, GAC_RESP_DECERR);
        run(32'h00000001, 32'h00000000);
        @(negedge clk);
        chk("start in ungated mode", acq_running, 1'h0);
        $display("t_regs done");
    endtask

    task automatic t_std();
        run(GAC_MODE_STD_GATE, 32'h00000000);
        gate(16'h0003);
        chk("odd gate segment", n_stored, 32'h0000000C);
        chk("pre gate data", first_data, gate_sample - 16'h0004);
        gate(16'h0028);
        wait_idle();
        chk("std total", n_stored, 32'h00000020);
        rd(GAC_IDX_STORED);
        chk("stored reg", rd_v, 32'h00000020);
        rd(GAC_IDX_STATUS);
        chk("status done", rd_v[2:0], 3'h2);
        $display("t_std done");
    endtask

    task automatic t_fifo_limit();
        wr(GAC_IDX_CHANS, 32'h00000001);
        run(GAC_MODE_FIFO_GATE, 32'h00000002);
        repeat (3) gate(16'h0003);
        wait_idle();
        chk("limited stored", n_stored, 32'h00000016);
        rd(GAC_IDX_GATES);
        chk("gates counted", rd_v, 32'h00000002);
        $display("t_fifo_limit done");
    endtask

    task automatic t_fifo_stop();
        run(GAC_MODE_FIFO_GATE, 32'h00000000);
        repeat (4) gate(16'h0002);
        @(negedge clk);
        chk("unlimited running", acq_running, 1'h1);
        chk("no size limit", n_stored, 32'h00000028);
        rd(GAC_IDX_STATUS);
        chk("status streaming", rd_v[2:0] & 3'h5, 3'h5);
        wr(GAC_IDX_CTRL, 32'h00000002);
        @(negedge clk);
        chk("stopped", acq_running, 1'h0);
        $display("t_fifo_stop done");
    endtask

    initial
    begin
        rst_n = 1'b0;
        awaddr = 16'h0000;
        awvalid = 1'b0;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 16'h0000;
        arvalid = 1'b0;
        rready = 1'b0;
        go = 1'b0;
        glen = 16'h0000;
        clr = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_std();
        t_fifo_limit();
        t_fifo_stop();
        give_verdict();
    end
endmodule
